// ==== logic/eeprom_slave_consts.vh ====
// Constants for the two-wire serial memory slave.
// Assumes inclusion by bare name from logic/.
`ifndef EEPROM_SLAVE_CONSTS_VH
`define EEPROM_SLAVE_CONSTS_VH
`define MEM_DEPTH        128
`define MEM_AW           7
// Fixed group code of the slave address; value is arbitrary
`define GROUP_CODE       4'h5
`define WORD_ADDR_RST    7'h00
`define PAGE_BYTES       8
`define CLK_PERIOD_NS    5
// Write cycle bounds in ms, printed figures
`define WR_TIME_MIN_MS   6
`define WR_TIME_MAX_MS   12
// Cycles for the write time, kept inside the 6..12 ms window by taking the minimum
`define WR_CYCLES        ((`WR_TIME_MIN_MS * 1000000) / `CLK_PERIOD_NS)
`endif

// ==== logic/eeprom_slave.v ====
// Two-wire bus slave with 128 x 8 memory, page write and timed write cycle.
// Assumes an external master drives the serial clock; pins are sampled by clock_i.
`timescale 1ns/10ps
`include "eeprom_slave_consts.vh"

module eeprom_slave #(
    parameter WR_CYCLES = `WR_CYCLES
) (
    input  wire       clock_i,
    input  wire       rst_n_i,
    input  wire       scl_i,
    input  wire       sda_i,
    output wire       sda_o,
    output wire       sda_oe_o,
    input  wire       hw_addr_pin_bit0_i,
    input  wire       hw_addr_pin_bit1_i,
    input  wire       hw_addr_pin_bit2_i,
    output wire       write_busy_o
);
    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_ADDR = 6'h02;
    localparam [5:0] ST_WORD = 6'h04;
    localparam [5:0] ST_WDAT = 6'h08;
    localparam [5:0] ST_RDAT = 6'h10;
    localparam [5:0] ST_RACK = 6'h20;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    reg  [1:0] scl_sync_ff;
    reg  [1:0] sda_sync_ff;
    reg  [2:0] pin_sync1_ff;
    reg  [2:0] pin_sync2_ff;
    reg        scl_ff;
    reg        sda_ff;
    always @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            scl_sync_ff  <= 2'h3;
            sda_sync_ff  <= 2'h3;
            pin_sync1_ff <= 3'h0;
            pin_sync2_ff <= 3'h0;
            scl_ff       <= 1'b1;
            sda_ff       <= 1'b1;
        end
        else
        begin
            scl_sync_ff  <= {scl_sync_ff[0], scl_i};
            sda_sync_ff  <= {sda_sync_ff[0], sda_i};
            pin_sync1_ff <= {hw_addr_pin_bit2_i, hw_addr_pin_bit1_i, hw_addr_pin_bit0_i};
            pin_sync2_ff <= pin_sync1_ff;
            scl_ff       <= scl_sync_ff[1];
            sda_ff       <= sda_sync_ff[1];
        end
    end
    wire scl_s    = scl_sync_ff[1];
    wire sda_s    = sda_sync_ff[1];
    wire scl_rise = scl_s & ~scl_ff;
    wire scl_fall = ~scl_s & scl_ff;
    wire start_det = scl_s & scl_ff & sda_ff & ~sda_s;
    wire stop_det  = scl_s & scl_ff & ~sda_ff & sda_s;

    // ----------------------------------------
    // Storage and state
    // ----------------------------------------
    reg  [7:0]  mem_ff [0:`MEM_DEPTH-1];
    reg  [7:0]  page_ff [0:`PAGE_BYTES-1];
    reg  [`PAGE_BYTES-1:0] page_vld_ff;
    reg  [5:0]  state_ff;
    reg  [3:0]  bit_cnt_ff;
    reg  [7:0]  shift_ff;
    reg  [6:0]  word_addr_ff;
    reg         ack_ff;
    reg         drive_low_ff;
    reg         busy_ff;
    reg         commit_ff;
    reg  [31:0] wr_cnt_ff;
    integer     i;

    wire addr_match = (shift_ff[7:4] == `GROUP_CODE) &&
                      (shift_ff[3:1] == pin_sync2_ff);
    wire [7:0] rx_byte = {shift_ff[6:0], sda_s};

    always @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            state_ff     <= ST_IDLE;
            bit_cnt_ff   <= 4'h0;
            shift_ff     <= 8'h00;
            word_addr_ff <= `WORD_ADDR_RST;
            ack_ff       <= 1'b0;
            drive_low_ff <= 1'b0;
            page_vld_ff  <= {`PAGE_BYTES{1'b0}};
            commit_ff    <= 1'b0;
        end
        else if (start_det)
        begin
            // A new start drops any partial transfer, page bytes included,
            // so a later stop never commits stale data
            state_ff     <= ST_ADDR;
            bit_cnt_ff   <= 4'h0;
            ack_ff       <= 1'b0;
            drive_low_ff <= 1'b0;
            commit_ff    <= 1'b0;
            page_vld_ff  <= {`PAGE_BYTES{1'b0}};
        end
        else if (stop_det)
        begin
            state_ff     <= ST_IDLE;
            drive_low_ff <= 1'b0;
            // A refused ninth byte leaves the state idle; the page still commits
            commit_ff    <= |page_vld_ff;
        end
        else
        begin
            commit_ff <= 1'b0;
            if (busy_ff)
                page_vld_ff <= {`PAGE_BYTES{1'b0}};
            case (state_ff)
                ST_IDLE: drive_low_ff <= 1'b0;
                ST_ADDR, ST_WORD, ST_WDAT:
                begin
                    if (scl_rise && !ack_ff)
                    begin
                        shift_ff   <= rx_byte;
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end
                    if (scl_fall && !ack_ff && bit_cnt_ff == 4'h8)
                    begin
                        bit_cnt_ff <= 4'h0;
                        if (state_ff == ST_ADDR)
                        begin
                            if (addr_match && !busy_ff)
                            begin
                                ack_ff       <= 1'b1;
                                drive_low_ff <= 1'b1;
                            end
                            else
                                state_ff <= ST_IDLE;
                        end
                        else if (state_ff == ST_WDAT && page_vld_ff[word_addr_ff[2:0]])
                            state_ff <= ST_IDLE;
                        else
                        begin
                            ack_ff       <= 1'b1;
                            drive_low_ff <= 1'b1;
                        end
                    end
                    else if (scl_fall && ack_ff)
                    begin
                        ack_ff       <= 1'b0;
                        drive_low_ff <= 1'b0;
                        if (state_ff == ST_ADDR && shift_ff[0])
                        begin
                            state_ff     <= ST_RDAT;
                            shift_ff     <= mem_ff[word_addr_ff];
                            drive_low_ff <= ~mem_ff[word_addr_ff][7];
                            word_addr_ff <= word_addr_ff + 7'h01;
                            bit_cnt_ff   <= 4'h1;
                        end
                        else if (state_ff == ST_ADDR)
                            state_ff <= ST_WORD;
                        else if (state_ff == ST_WORD)
                        begin
                            word_addr_ff <= shift_ff[6:0];
                            state_ff     <= ST_WDAT;
                        end
                        else
                        begin
                            // Only acknowledged bytes land in the page buffer
                            page_ff[word_addr_ff[2:0]]     <= shift_ff;
                            page_vld_ff[word_addr_ff[2:0]] <= 1'b1;
                            word_addr_ff <= {word_addr_ff[6:3],
                                             word_addr_ff[2:0] + 3'h1};
                        end
                    end
                end
                ST_RDAT:
                begin
                    if (scl_fall)
                    begin
                        if (bit_cnt_ff == 4'h8)
                        begin
                            drive_low_ff <= 1'b0;
                            state_ff     <= ST_RACK;
                        end
                        else
                        begin
                            drive_low_ff <= ~shift_ff[6];
                            shift_ff     <= {shift_ff[6:0], 1'b0};
                            bit_cnt_ff   <= bit_cnt_ff + 4'h1;
                        end
                    end
                end
                ST_RACK:
                begin
                    if (scl_rise)
                        ack_ff <= ~sda_s;
                    if (scl_fall)
                    begin
                        if (ack_ff)
                        begin
                            state_ff     <= ST_RDAT;
                            shift_ff     <= mem_ff[word_addr_ff];
                            drive_low_ff <= ~mem_ff[word_addr_ff][7];
                            word_addr_ff <= word_addr_ff + 7'h01;
                            bit_cnt_ff   <= 4'h1;
                            ack_ff       <= 1'b0;
                        end
                        else
                            state_ff <= ST_IDLE;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Write cycle timer
    // ----------------------------------------
    // Erase and program are one overwrite of the byte; the timer covers both
    always @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            busy_ff   <= 1'b0;
            wr_cnt_ff <= 32'h0;
        end
        else if (commit_ff)
        begin
            busy_ff   <= 1'b1;
            wr_cnt_ff <= 32'h0;
            for (i = 0; i < `PAGE_BYTES; i = i + 1)
                if (page_vld_ff[i])
                    mem_ff[{word_addr_ff[6:3], i[2:0]}] <= page_ff[i];
        end
        else if (busy_ff)
        begin
            if (wr_cnt_ff == WR_CYCLES - 1)
                busy_ff <= 1'b0;
            wr_cnt_ff <= wr_cnt_ff + 32'h1;
        end
    end

    // Open drain: only ever pull low
    assign sda_o        = 1'b0;
    assign sda_oe_o     = drive_low_ff;
    assign write_busy_o = busy_ff;
endmodule

// ==== dv/eeprom_slave_asserts.sv ====
// Port checker for the serial memory slave, bound onto eeprom_slave.
// Assumes one clock domain and a scaled write time parameter.
`timescale 1ns/10ps
module eeprom_slave_asserts #(
    parameter WR_CYCLES = 200
) (
    input wire clock_i,
    input wire rst_n_i,
    input wire scl_i,
    input wire sda_i,
    input wire sda_o,
    input wire sda_oe_o,
    input wire hw_addr_pin_bit0_i,
    input wire hw_addr_pin_bit1_i,
    input wire hw_addr_pin_bit2_i,
    input wire write_busy_o
);
    // ----------
    // Properties
    // ----------
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    int bc_ff;
    always @(posedge clock_i)
    begin
        if (!rst_n_i || !write_busy_o)
            bc_ff <= 0;
        else
            bc_ff <= bc_ff + 1;
    end
    drive_low_a: assert property (sda_o == 1'b0)
        else $error("sda_o not low");
    oe_edge_a: assert property ($changed(sda_oe_o) |-> !scl_i && !$past(scl_i, 2))
        else $error("sda_oe_o moved near scl high");
    ack_hold_a: assert property (sda_oe_o && $rose(scl_i) |-> sda_oe_o [*4])
        else $error("pull dropped in scl high");
    busy_silent_a: assert property (write_busy_o |-> !sda_oe_o)
        else $error("answer during write");
    busy_len_a: assert property ($fell(write_busy_o) |-> bc_ff >= WR_CYCLES - 1)
        else $error("write cycle short");
    busy_cap_a: assert property (write_busy_o |-> bc_ff <= WR_CYCLES + 1)
        else $error("write cycle long");
    busy_after_stop_a: assert property ($rose(write_busy_o) |-> scl_i && sda_i)
        else $error("write began without stop");
    wake_idle_a: assert property ($rose(rst_n_i) |-> (!sda_oe_o && !write_busy_o) [*8])
        else $error("not idle after reset");
    cover property ($fell(write_busy_o));
    cover property ($rose(sda_oe_o));
    cover property (sda_oe_o && $rose(scl_i));
endmodule

bind eeprom_slave eeprom_slave_asserts #(.WR_CYCLES(WR_CYCLES)) u_asserts (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .hw_addr_pin_bit0_i(hw_addr_pin_bit0_i),
    .hw_addr_pin_bit1_i(hw_addr_pin_bit1_i), .hw_addr_pin_bit2_i(hw_addr_pin_bit2_i),
    .write_busy_o(write_busy_o));

// ==== dv/i2c_master_model.sv ====
// Two-wire bus master model: drives the link clock and its share of the data line.
// Assumes the data wire is resolved outside with a pull-up; 48 ns per bit.
`timescale 1ns/10ps
module i2c_master_model (
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    // ----------
    // Bus actions
    // ----------
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // Data moves mid-low, sampled mid-high, so setup and hold both get 12 ns
    task automatic xfer(input logic b, output logic q);
        #12 sda_o = b;
        #12 scl_o = 1'b1;
        #12 q = sda_i;
        #12 scl_o = 1'b0;
    endtask
    task automatic start();
        #12 sda_o = 1'b1;
        #12 scl_o = 1'b1;
        #24 sda_o = 1'b0;
        #24 scl_o = 1'b0;
    endtask
    task automatic stop();
        #12 sda_o = 1'b0;
        #12 scl_o = 1'b1;
        #24 sda_o = 1'b1;
        #24;
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic q;
        for (int i = 7; i >= 0; i--)
            xfer(b[i], q);
        xfer(1'b1, q);
        ack = ~q;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic q;
        for (int i = 7; i >= 0; i--)
            xfer(1'b1, d[i]);
        xfer(last, q);
    endtask
endmodule

// ==== dv/tb_top.sv ====
// Bench for the serial memory slave: page write, reads, address pins, reset.
// Assumes the master model and checker compile first and the header is on the path.
`timescale 1ns/10ps
`include "eeprom_slave_consts.vh"
module tb_top;
    logic       clock_i      = 1'b0;
    logic       rst_n_i      = 1'b0;
    logic [2:0] pins         = 3'b101;
    logic [7:0] a            = 8'h00;
    logic [7:0] d;
    int         bad_count    = 0;
    int         total_checks = 0;
    wire        scl;
    wire        m_sda;
    wire        sda_oe;
    wire        busy;
    wire        sda = m_sda & ~sda_oe;
    always #2.5 clock_i = ~clock_i;
    eeprom_slave #(.WR_CYCLES(200)) uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .scl_i(scl),
        .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .hw_addr_pin_bit0_i(pins[0]),
        .hw_addr_pin_bit1_i(pins[1]), .hw_addr_pin_bit2_i(pins[2]), .write_busy_o(busy));
    i2c_master_model m (.sda_i(sda), .scl_o(scl), .sda_o(m_sda));
    task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wait_busy(input logic lvl, input int lim);
        repeat (lim)
            if (busy !== lvl)
                @(negedge clock_i);
        chk("write_busy_o", {7'h00, lvl}, {7'h00, busy});
        if (busy !== lvl)
            complete_run();
    endtask
    task automatic hdr(input logic [2:0] p, input logic rd, input logic [7:0] e);
        m.start();
        m.wbyte({`GROUP_CODE, p, rd}, a[0]);
        chk("address ack", e, a);
    endtask
    task automatic s_page_write();
        hdr(pins, 1'b0, 8'h01);
        m.wbyte(8'h8b, a[0]);
        chk("word ack", 8'h01, a);
        for (int i = 0; i < `PAGE_BYTES; i++)
        begin
            m.wbyte(8'ha0 + 8'(i), a[0]);
            chk("data ack", 8'h01, a);
        end
        m.wbyte(8'h5a, a[0]);
        chk("ninth ack", 8'h00, a);
        m.stop();
        wait_busy(1'b1, 20);
        hdr(pins, 1'b0, 8'h00);
        m.stop();
        wait_busy(1'b0, 400);
    endtask
    task automatic s_read();
        hdr(pins, 1'b0, 8'h01);
        m.wbyte(8'h08, a[0]);
        hdr(pins, 1'b1, 8'h01);
        for (int i = 0; i < 7; i++)
        begin
            m.rbyte(i == 6, d);
            chk("read", 8'ha0 + 8'((i + 5) % 8), d);
        end
        m.stop();
        chk("release", 8'h00, {7'h00, sda_oe});
        hdr(pins, 1'b1, 8'h01);
        m.rbyte(1'b1, d);
        chk("current read", 8'ha4, d);
        m.stop();
    endtask
    task automatic s_pins();
        for (int q = 0; q < 2; q++)
        begin
            @(negedge clock_i) pins = q ? 3'b010 : 3'b101;
            for (int p = 0; p < 8; p++)
            begin
                hdr(3'(p), 1'b1, {7'h00, 3'(p) == pins});
                if (a[0] === 1'b1)
                    m.rbyte(1'b1, d);
                m.stop();
            end
        end
        m.start();
        m.wbyte({4'h3, pins, 1'b1}, a[0]);
        chk("group ack", 8'h00, a);
        m.stop();
    endtask
    task automatic s_reset();
        hdr(pins, 1'b0, 8'h01);
        m.wbyte(8'h20, a[0]);
        m.wbyte(8'h77, a[0]);
        @(negedge clock_i) rst_n_i = 1'b0;
        repeat (3) @(negedge clock_i);
        rst_n_i = 1'b1;
        m.stop();
        repeat (20) @(negedge clock_i);
        chk("busy after reset", 8'h00, {7'h00, busy});
    endtask
    initial
    begin
        repeat (20) @(negedge clock_i);
        rst_n_i = 1'b1;
        repeat (8) @(negedge clock_i);
        s_page_write();
        s_read();
        s_pins();
        s_reset();
        complete_run();
    end
endmodule
